// ### amp_ctrl_pkg.sv
// Constants shared by the amplifier control register bank.
// Assumes a 100 MHz system clock and a two-wire serial host on the pins.
package amp_ctrl_pkg;

  // ****************************************************************
  // Bus addressing
  // ****************************************************************
  localparam logic [7:0] WR_ADDR_BYTE = 8'hb0;
  localparam logic [7:0] RD_ADDR_BYTE = 8'hb1;

  // ****************************************************************
  // Register offsets and reset values
  // ****************************************************************
  localparam logic [7:0] FUNC_OFS  = 8'h01;
  localparam logic [7:0] ATK_OFS   = 8'h02;
  localparam logic [7:0] REL_OFS   = 8'h03;
  localparam logic [7:0] HOLD_OFS  = 8'h04;
  localparam logic [7:0] GAIN_OFS  = 8'h05;
  localparam logic [7:0] LIM_OFS   = 8'h06;
  localparam logic [7:0] CEIL_OFS  = 8'h07;

  localparam logic [7:0] FUNC_RST  = 8'hc3;
  localparam logic [7:0] ATK_RST   = 8'h05;
  localparam logic [7:0] REL_RST   = 8'h0b;
  localparam logic [7:0] HOLD_RST  = 8'h00;
  localparam logic [7:0] GAIN_RST  = 8'h06;
  localparam logic [7:0] LIM_RST   = 8'h3a;
  localparam logic [7:0] CEIL_RST  = 8'hc2;
  localparam logic [7:0] CEIL_MASK = 8'hf3;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // ****************************************************************
  // Function control bit positions
  // ****************************************************************
  localparam int AMP_ON_BIT        = 6;
  localparam int SOFT_SHUTDOWN_BIT = 5;
  localparam int FAULT_BIT         = 3;
  localparam int THERMAL_BIT       = 2;
  localparam int NOISE_GATE_ON_BIT = 0;
  localparam logic [1:0] RATIO_ONE_TO_ONE = 2'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS     = 10000;
  localparam int ATTACK_UNIT_PS    = 106700000;
  localparam int RELEASE_UNIT_US   = 13700;
  localparam int ATTACK_UNIT_CYC   = ATTACK_UNIT_PS / CLK_PERIOD_PS;
  localparam int RELEASE_UNIT_CYC  = (RELEASE_UNIT_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int THERM_DEGLITCH_CYC = 16;

endpackage : amp_ctrl_pkg

// ### step_gap_timer.sv
// Interval timer: stays busy for code times UNIT_CYCLES clocks after start.
// Assumes start pulses come from logic on the same clock.
`timescale 1ns/100ps
module step_gap_timer #(
  parameter int unsigned UNIT_CYCLES = 16
) (
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic       start_i,
  input  wire logic [5:0] code_i,
  output logic            busy_o
);

  logic [21:0] unit_cnt_q;
  logic [5:0]  left_q;

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || start_i)
    begin
      unit_cnt_q <= 22'h0;
      left_q     <= srst_i ? 6'h00 : code_i;
    end
    else if (left_q != 6'h00)
    begin
      if (unit_cnt_q == 22'(UNIT_CYCLES - 1))
      begin
        unit_cnt_q <= 22'h0;
        left_q     <= left_q - 6'h01;
      end
      else
      begin
        unit_cnt_q <= unit_cnt_q + 22'h1;
      end
    end
  end

  assign busy_o = (left_q != 6'h00);

endmodule : step_gap_timer

// ### amp_agc_ctrl.sv
// Control and status registers of a mono amplifier with gain control,
// reached over a two-wire serial bus, plus gain step pacing.
// Assumes scl/sda/enable/fault pins are asynchronous to sys_clk_i.
`timescale 1ns/100ps
// Functional notes
// R1: Device answers address byte b0 for writes and b1 for reads.
// R2: Reset loads registers one to seven with C3,05,0B,00,06,3A,C2.
// R3: Host must not write above address 08; such writes are dropped.
// R4: Reads of reserved locations return an arbitrary value, here zero.
// R5: Amp bit enables channel; thermal shutdown forces it off until cooled.
// R6: Soft shutdown bit set turns control, bias and oscillator off.
// R7: Fault bit sets on output short, stays until host writes zero.
// R8: Thermal bit sets on deglitched over-temperature, cleared by writing zero.
// R9: Noise gate bit enables gate only when ratio is not 1:1.
// R10: Attack code sets ramp-down rate, 0.1067 ms per code step.
// R11: Gain decreases are spaced by at least the attack interval.
// R12: Unused bits ignore writes and read their fixed default values.
// R13: Gain increases are spaced by release interval, 0.0137 s per code.
// R14: Hold interval separates decrease from next increase; code zero disables.
// R15: Fixed gain field is two's complement dB, zero meaning 0 dB.
// R16: Enable pin low shuts everything and restores all register defaults.
module amp_agc_ctrl #(
  parameter int unsigned ATTACK_UNIT_CYCLES  = amp_ctrl_pkg::ATTACK_UNIT_CYC,
  parameter int unsigned RELEASE_UNIT_CYCLES = amp_ctrl_pkg::RELEASE_UNIT_CYC
) (
  input  wire logic              sys_clk_i,
  input  wire logic              srst_i,
  input  wire logic              enable_pin_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n_o,
  input  wire logic              short_i,
  input  wire logic              overtemp_i,
  input  wire logic              gain_dec_req_i,
  input  wire logic              gain_inc_req_i,
  output logic                   gain_dec_ok_o,
  output logic                   gain_inc_ok_o,
  output logic                   amp_on_o,
  output logic                   bias_on_o,
  output logic                   gate_on_o,
  output logic signed [5:0]      base_gain_code_o,
  output logic [5:0]             attack_step_code_o,
  output logic [7:0]             limiter_gate_o,
  output logic [7:0]             ceiling_ratio_o
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR  = 3'b010,
    ST_WR   = 3'b011,
    ST_RD   = 3'b100
  } bus_state_t;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] scl_s_q, sda_s_q, en_s_q, short_s_q, temp_s_q;
  logic       scl_d1_q, sda_d1_q;

  always_ff @(posedge sys_clk_i)
  begin
    scl_s_q   <= {scl_s_q[0], scl_i};
    sda_s_q   <= {sda_s_q[0], sda_i};
    en_s_q    <= {en_s_q[0], enable_pin_i};
    short_s_q <= {short_s_q[0], short_i};
    temp_s_q  <= {temp_s_q[0], overtemp_i};
    scl_d1_q  <= scl_s_q[1];
    sda_d1_q  <= sda_s_q[1];
  end

  logic clear, scl_rise, scl_fall, bus_start, bus_stop;
  assign clear     = srst_i || !en_s_q[1]; // R16
  assign scl_rise  = scl_s_q[1] && !scl_d1_q;
  assign scl_fall  = !scl_s_q[1] && scl_d1_q;
  assign bus_start = scl_s_q[1] && scl_d1_q && sda_d1_q && !sda_s_q[1];
  assign bus_stop  = scl_s_q[1] && scl_d1_q && !sda_d1_q && sda_s_q[1];

  // ****************************************************************
  // Two-wire serial slave
  // ****************************************************************
  bus_state_t st_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] sh_q, ptr_q, rd_data;
  logic       ack_q, nack_q, drive_q, wr_stb;

  assign wr_stb = scl_fall && !ack_q && bit_cnt_q == 4'h8 && st_q == ST_WR;

  always_ff @(posedge sys_clk_i)
  begin
    if (clear || bus_stop)
    begin
      st_q <= ST_IDLE;
      ack_q <= 1'b0;
      bit_cnt_q <= 4'h0;
      if (clear)
      begin
        ptr_q <= 8'h00;
      end
    end
    else if (bus_start)
    begin
      st_q <= ST_ADDR;
      ack_q <= 1'b0;
      bit_cnt_q <= 4'h0;
    end
    else if (scl_rise && st_q != ST_IDLE)
    begin
      if (ack_q)
      begin
        nack_q <= sda_s_q[1];
      end
      else
      begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (st_q != ST_RD)
        begin
          sh_q <= {sh_q[6:0], sda_s_q[1]};
        end
      end
    end
    else if (scl_fall && st_q != ST_IDLE)
    begin
      if (!ack_q && bit_cnt_q != 4'h8)
      begin
        if (st_q == ST_RD)
        begin
          sh_q <= {sh_q[6:0], 1'b0};
        end
      end
      else if (!ack_q)
      begin
        ack_q <= 1'b1;
        unique case (st_q)
          ST_ADDR:
          begin
            if (sh_q[7:1] != amp_ctrl_pkg::WR_ADDR_BYTE[7:1]) // R1
            begin
              st_q <= ST_IDLE;
            end
          end
          ST_PTR:  ptr_q <= sh_q;
          ST_WR:   ptr_q <= ptr_q + 8'h01;
          ST_RD:   ptr_q <= ptr_q;
          ST_IDLE: ptr_q <= ptr_q;
        endcase
      end
      else
      begin
        ack_q <= 1'b0;
        bit_cnt_q <= 4'h0;
        unique case (st_q)
          ST_ADDR:
          begin
            st_q <= sh_q[0] ? ST_RD : ST_PTR; // R1
            if (sh_q[0])
            begin
              sh_q  <= rd_data;
              ptr_q <= ptr_q + 8'h01;
            end
          end
          ST_PTR:  st_q <= ST_WR;
          ST_WR:   st_q <= ST_WR;
          ST_RD:
          begin
            st_q  <= nack_q ? ST_IDLE : ST_RD;
            sh_q  <= rd_data;
            ptr_q <= nack_q ? ptr_q : ptr_q + 8'h01;
          end
          ST_IDLE: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (clear)
    begin
      drive_q <= 1'b0;
    end
    else
    begin
      drive_q <= (ack_q && (st_q == ST_ADDR || st_q == ST_PTR || st_q == ST_WR))
                 || (!ack_q && st_q == ST_RD && !sh_q[7]);
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe_n_o = !drive_q;

  // ****************************************************************
  // Register bank
  // ****************************************************************
  logic       amp_bit_q, sws_q, fault_q, therm_q, ng_q;
  logic [5:0] atk_q, rel_q, hold_q, gain_q;
  logic [7:0] lim_q, ceil_q, func_rd;
  logic [4:0] glitch_cnt_q;
  logic       therm_on;

  always_ff @(posedge sys_clk_i)
  begin
    if (clear || !temp_s_q[1])
    begin
      glitch_cnt_q <= 5'h00;
    end
    else if (!therm_on)
    begin
      glitch_cnt_q <= glitch_cnt_q + 5'h01;
    end
  end
  assign therm_on = (glitch_cnt_q == 5'(amp_ctrl_pkg::THERM_DEGLITCH_CYC)); // R8

  always_ff @(posedge sys_clk_i)
  begin
    if (clear) // R2 R16
    begin
      amp_bit_q <= amp_ctrl_pkg::FUNC_RST[amp_ctrl_pkg::AMP_ON_BIT];
      sws_q     <= amp_ctrl_pkg::FUNC_RST[amp_ctrl_pkg::SOFT_SHUTDOWN_BIT];
      ng_q      <= amp_ctrl_pkg::FUNC_RST[amp_ctrl_pkg::NOISE_GATE_ON_BIT];
      atk_q     <= amp_ctrl_pkg::ATK_RST[5:0];
      rel_q     <= amp_ctrl_pkg::REL_RST[5:0];
      hold_q    <= amp_ctrl_pkg::HOLD_RST[5:0];
      gain_q    <= amp_ctrl_pkg::GAIN_RST[5:0];
      lim_q     <= amp_ctrl_pkg::LIM_RST;
      ceil_q    <= amp_ctrl_pkg::CEIL_RST;
    end
    else if (wr_stb) // R3 R12
    begin
      unique case (ptr_q)
        amp_ctrl_pkg::FUNC_OFS:
        begin
          amp_bit_q <= sh_q[amp_ctrl_pkg::AMP_ON_BIT];
          sws_q     <= sh_q[amp_ctrl_pkg::SOFT_SHUTDOWN_BIT];
          ng_q      <= sh_q[amp_ctrl_pkg::NOISE_GATE_ON_BIT];
        end
        amp_ctrl_pkg::ATK_OFS:  atk_q  <= sh_q[5:0]; // R10
        amp_ctrl_pkg::REL_OFS:  rel_q  <= sh_q[5:0];
        amp_ctrl_pkg::HOLD_OFS: hold_q <= sh_q[5:0];
        amp_ctrl_pkg::GAIN_OFS: gain_q <= sh_q[5:0];
        amp_ctrl_pkg::LIM_OFS:  lim_q  <= sh_q;
        amp_ctrl_pkg::CEIL_OFS: ceil_q <= sh_q & amp_ctrl_pkg::CEIL_MASK;
        default:                lim_q  <= lim_q;
      endcase
    end
  end

  logic clr_wr;
  assign clr_wr = wr_stb && ptr_q == amp_ctrl_pkg::FUNC_OFS;

  always_ff @(posedge sys_clk_i)
  begin
    if (clear)
    begin
      fault_q <= 1'b0;
      therm_q <= 1'b0;
    end
    else
    begin
      fault_q <= short_s_q[1] || (fault_q && !(clr_wr && !sh_q[amp_ctrl_pkg::FAULT_BIT])); // R7
      therm_q <= therm_on || (therm_q && !(clr_wr && !sh_q[amp_ctrl_pkg::THERMAL_BIT])); // R8
    end
  end

  always_comb
  begin
    func_rd = amp_ctrl_pkg::FUNC_RST; // R12
    func_rd[amp_ctrl_pkg::AMP_ON_BIT]        = amp_bit_q;
    func_rd[amp_ctrl_pkg::SOFT_SHUTDOWN_BIT] = sws_q;
    func_rd[amp_ctrl_pkg::FAULT_BIT]         = fault_q;
    func_rd[amp_ctrl_pkg::THERMAL_BIT]       = therm_q;
    func_rd[amp_ctrl_pkg::NOISE_GATE_ON_BIT] = ng_q;
    unique case (ptr_q)
      amp_ctrl_pkg::FUNC_OFS: rd_data = func_rd;
      amp_ctrl_pkg::ATK_OFS:  rd_data = {2'h0, atk_q};
      amp_ctrl_pkg::REL_OFS:  rd_data = {2'h0, rel_q};
      amp_ctrl_pkg::HOLD_OFS: rd_data = {2'h0, hold_q};
      amp_ctrl_pkg::GAIN_OFS: rd_data = {2'h0, gain_q};
      amp_ctrl_pkg::LIM_OFS:  rd_data = lim_q;
      amp_ctrl_pkg::CEIL_OFS: rd_data = ceil_q;
      default:                rd_data = amp_ctrl_pkg::UNMAPPED_RD; // R4
    endcase
  end

  // ****************************************************************
  // Control outputs and gain step pacing
  // ****************************************************************
  assign amp_on_o  = amp_bit_q && !sws_q && !therm_on && !clear; // R5
  assign bias_on_o = !sws_q && !clear; // R6
  assign gate_on_o = ng_q && ceil_q[1:0] != amp_ctrl_pkg::RATIO_ONE_TO_ONE && !clear; // R9 R16
  assign base_gain_code_o   = $signed(gain_q); // R15
  assign attack_step_code_o = atk_q;
  assign limiter_gate_o     = lim_q;
  assign ceiling_ratio_o    = ceil_q;

  logic atk_busy, rel_busy, hold_busy;
  assign gain_dec_ok_o = gain_dec_req_i && bias_on_o && !atk_busy; // R11
  assign gain_inc_ok_o = gain_inc_req_i && bias_on_o && !rel_busy && !hold_busy; // R13 R14

  step_gap_timer #(.UNIT_CYCLES(ATTACK_UNIT_CYCLES)) u_attack (
    .sys_clk_i (sys_clk_i),
    .srst_i    (clear),
    .start_i   (gain_dec_ok_o),
    .code_i    (atk_q),
    .busy_o    (atk_busy)
  );
  step_gap_timer #(.UNIT_CYCLES(RELEASE_UNIT_CYCLES)) u_release (
    .sys_clk_i (sys_clk_i),
    .srst_i    (clear),
    .start_i   (gain_inc_ok_o),
    .code_i    (rel_q),
    .busy_o    (rel_busy)
  );
  step_gap_timer #(.UNIT_CYCLES(RELEASE_UNIT_CYCLES)) u_hold (
    .sys_clk_i (sys_clk_i),
    .srst_i    (clear),
    .start_i   (gain_dec_ok_o),
    .code_i    (hold_q),
    .busy_o    (hold_busy)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_fault_clr;
    clr_wr && !sh_q[amp_ctrl_pkg::FAULT_BIT] && !short_s_q[1];
  endsequence

  a_fault_sticky: assert property (@(posedge sys_clk_i) disable iff (clear) // R7
    fault_q && !(clr_wr && !sh_q[amp_ctrl_pkg::FAULT_BIT]) |=> fault_q)
    else $error("fault flag lost");
  a_fault_clear: assert property (@(posedge sys_clk_i) disable iff (clear) // R7
    s_fault_clr |=> !fault_q) else $error("fault flag not cleared");
  a_fault_set: assert property (@(posedge sys_clk_i) disable iff (clear) // R7
    short_s_q[1] |=> fault_q) else $error("fault flag not set");
  a_thermal_latch: assert property (@(posedge sys_clk_i) disable iff (clear) // R8
    therm_on |-> !amp_on_o ##1 therm_q) else $error("thermal flag not latched");
  a_amp_gating: assert property (@(posedge sys_clk_i) disable iff (srst_i) // R5
    amp_on_o |-> amp_bit_q && !therm_on && !sws_q) else $error("amp on while gated");
  a_soft_down: assert property (@(posedge sys_clk_i) disable iff (srst_i) // R6
    sws_q |-> !bias_on_o && !gain_dec_ok_o) else $error("bias on in shutdown");
  a_gate_ratio: assert property (@(posedge sys_clk_i) disable iff (srst_i) // R9
    gate_on_o |-> ng_q && ceil_q[1:0] != amp_ctrl_pkg::RATIO_ONE_TO_ONE)
    else $error("gate on at 1:1");
  a_attack_gap: assert property (@(posedge sys_clk_i) disable iff (clear) // R11
    gain_dec_ok_o && atk_q != 6'h00 |=> !gain_dec_ok_o) else $error("decrease too soon");
  a_hold_gap: assert property (@(posedge sys_clk_i) disable iff (clear) // R14
    gain_dec_ok_o && hold_q != 6'h00 |=> !gain_inc_ok_o [*2]) else $error("increase in hold");
  a_release_gap: assert property (@(posedge sys_clk_i) disable iff (clear) // R13
    gain_inc_ok_o && rel_q != 6'h00 |=> !gain_inc_ok_o) else $error("increase too soon");
  a_pin_default: assert property (@(posedge sys_clk_i) // R16
    $past(clear) |-> func_rd == amp_ctrl_pkg::FUNC_RST && lim_q == amp_ctrl_pkg::LIM_RST)
    else $error("no defaults");

endmodule : amp_agc_ctrl

// ### serial_host_model.sv
// Two-wire bus host: start, stop, byte out with ack, byte in with ack.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/100ps
module serial_host_model (
  input  wire logic sys_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // ****************************************************************
  // Bus phases, all changes made just after a rising edge
  // ****************************************************************
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic half;
    repeat (10) @(posedge sys_clk_i);
  endtask : half

  task automatic clk_bit(output logic v);
    half();
    scl_o <= 1'b1;
    half();
    v = sda_i;
    scl_o <= 1'b0;
    half();
  endtask : clk_bit

  task automatic start;
    sda_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    sda_o <= 1'b0;
    half();
    scl_o <= 1'b0;
    half();
  endtask : start

  task automatic stop;
    sda_o <= 1'b0;
    half();
    scl_o <= 1'b1;
    half();
    sda_o <= 1'b1;
    half();
  endtask : stop

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--)
    begin
      sda_o <= b[i];
      clk_bit(v);
    end
    sda_o <= 1'b1;
    clk_bit(v);
    ack = ~v;
  endtask : put_byte

  task automatic get_byte(input logic last, output logic [7:0] b);
    logic v;
    for (int i = 7; i >= 0; i--)
    begin
      sda_o <= 1'b1;
      clk_bit(v);
      b[i] = v;
    end
    sda_o <= last;
    clk_bit(v);
  endtask : get_byte
endmodule : serial_host_model

// ### amp_agc_control_registers_tb_top.sv
// Self-checking bench for the amplifier control register bank.
// Assumes amp_agc_ctrl and serial_host_model are compiled before it.
`timescale 1ns/100ps
module amp_agc_control_registers_tb_top;
  logic              sys_clk_i;
  logic              srst_i;
  logic              enable_pin_i;
  logic              short_i;
  logic              overtemp_i;
  logic              dec_req;
  logic              inc_req;
  logic              scl;
  logic              host_sda;
  logic              sda_o;
  logic              sda_oe_n_o;
  logic              dec_ok;
  logic              inc_ok;
  logic              amp_on;
  logic              bias_on;
  logic              gate_on;
  logic signed [5:0] base_gain;
  logic [5:0]        attack_code;
  logic [7:0]        lim_out;
  logic [7:0]        ceil_out;
  wire               sda_line = host_sda & (sda_oe_n_o | sda_o);
  int                failures;
  int                total_checks;

  amp_agc_ctrl #(.ATTACK_UNIT_CYCLES(4), .RELEASE_UNIT_CYCLES(8)) dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .enable_pin_i(enable_pin_i),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .short_i(short_i), .overtemp_i(overtemp_i),
    .gain_dec_req_i(dec_req), .gain_inc_req_i(inc_req),
    .gain_dec_ok_o(dec_ok), .gain_inc_ok_o(inc_ok),
    .amp_on_o(amp_on), .bias_on_o(bias_on), .gate_on_o(gate_on),
    .base_gain_code_o(base_gain), .attack_step_code_o(attack_code),
    .limiter_gate_o(lim_out), .ceiling_ratio_o(ceil_out));

  serial_host_model host (.sys_clk_i(sys_clk_i), .sda_i(sda_line), .scl_o(scl),
                          .sda_o(host_sda));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    logic a0, a1, a2;
    host.start();
    host.put_byte(8'hb0, a0);
    host.put_byte(ptr, a1);
    host.put_byte(data, a2);
    host.stop();
    chk({5'h0, a0, a1, a2}, 8'h07);
  endtask : wr

  task automatic rchk(input logic [7:0] ptr, input logic [7:0] exp);
    logic a0, a1, a2;
    logic [7:0] d;
    host.start();
    host.put_byte(8'hb0, a0);
    host.put_byte(ptr, a1);
    host.start();
    host.put_byte(8'hb1, a2);
    host.get_byte(1'b1, d);
    host.stop();
    chk({5'h0, a0, a1, a2}, 8'h07);
    chk(d, exp);
  endtask : rchk

  task automatic outs(input logic [7:0] exp);
    chk({5'h0, gate_on, bias_on, amp_on}, exp);
  endtask : outs

  task automatic wait_grant(input logic inc, output int n);
    for (n = 0; n < 300; n++)
    begin
      @(negedge sys_clk_i);
      if ((inc ? inc_ok : dec_ok) === 1'b1)
        break;
    end
    if (n == 300)
    begin
      failures++;
      summarize();
    end
  endtask : wait_grant

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_defaults;
    logic [7:0] dflt [1:7] = '{8'hc3, 8'h05, 8'h0b, 8'h00, 8'h06, 8'h3a, 8'hc2};
    for (int i = 1; i <= 7; i++)
      rchk(8'(i), dflt[i]);
    chk(lim_out, 8'h3a);
    chk(ceil_out, 8'hc2);
  endtask : t_defaults

  task automatic t_address;
    logic a;
    host.start();
    host.put_byte(8'ha0, a);
    host.stop();
    chk({7'h0, a}, 8'h00);
  endtask : t_address

  task automatic t_fields;
    wr(8'h02, 8'hff);
    rchk(8'h02, 8'h3f);
    chk({2'h0, attack_code}, 8'h3f);
    wr(8'h05, 8'hfc);
    chk({2'h0, base_gain}, 8'h3c);
    wr(8'h07, 8'hff);
    rchk(8'h07, 8'hf3);
    chk(ceil_out, 8'hf3);
    wr(8'h01, 8'hff);
    rchk(8'h01, 8'he3);
    outs(8'h04);
    wr(8'h01, 8'h00);
    rchk(8'h01, 8'h82);
    outs(8'h02);
    wr(8'h01, 8'hc3);
    outs(8'h07);
    wr(8'h07, 8'hf0);
    outs(8'h03);
    wr(8'h07, 8'hc2);
    outs(8'h07);
    wr(8'h01, 8'hc2);
    outs(8'h03);
    wr(8'h01, 8'hc3);
  endtask : t_fields

  task automatic t_reserved;
    wr(8'h09, 8'h55);
    rchk(8'h09, 8'h00);
    rchk(8'h01, 8'hc3);
  endtask : t_reserved

  task automatic t_fault;
    @(posedge sys_clk_i);
    short_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    short_i <= 1'b0;
    rchk(8'h01, 8'hcb);
    wr(8'h01, 8'hcb);
    rchk(8'h01, 8'hcb);
    wr(8'h01, 8'hc3);
    rchk(8'h01, 8'hc3);
  endtask : t_fault

  task automatic t_thermal;
    int n;
    @(posedge sys_clk_i);
    overtemp_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    overtemp_i <= 1'b0;
    rchk(8'h01, 8'hc3);
    overtemp_i <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge sys_clk_i);
      if (amp_on === 1'b0)
        break;
    end
    chk({7'h0, n >= 16 && n < 30}, 8'h01);
    rchk(8'h01, 8'hc7);
    outs(8'h06);
    overtemp_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    outs(8'h07);
    rchk(8'h01, 8'hc7);
    wr(8'h01, 8'hc3);
    rchk(8'h01, 8'hc3);
  endtask : t_thermal

  task automatic t_pacing;
    int n;
    wr(8'h02, 8'h05);
    wr(8'h04, 8'h02);
    @(posedge sys_clk_i);
    dec_req <= 1'b1;
    wait_grant(1'b0, n);
    wait_grant(1'b0, n);
    chk({7'h0, n >= 19 && n <= 21}, 8'h01);
    @(posedge sys_clk_i);
    dec_req <= 1'b0;
    inc_req <= 1'b1;
    wait_grant(1'b1, n);
    chk({7'h0, n >= 13 && n <= 17}, 8'h01);
    wait_grant(1'b1, n);
    chk({7'h0, n >= 86 && n <= 89}, 8'h01);
    @(posedge sys_clk_i);
    inc_req <= 1'b0;
  endtask : t_pacing

  task automatic t_enable;
    wr(8'h03, 8'h3f);
    @(posedge sys_clk_i);
    enable_pin_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    outs(8'h00);
    enable_pin_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    rchk(8'h03, 8'h0b);
    rchk(8'h04, 8'h00);
  endtask : t_enable

  initial
  begin
    srst_i = 1'b1;
    enable_pin_i = 1'b1;
    short_i = 1'b0;
    overtemp_i = 1'b0;
    dec_req = 1'b0;
    inc_req = 1'b0;
    failures = 0;
    total_checks = 0;
    repeat (4) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    t_defaults();
    t_address();
    t_fields();
    t_reserved();
    t_fault();
    t_thermal();
    t_pacing();
    t_enable();
    summarize();
  end
endmodule : amp_agc_control_registers_tb_top
